// >>> verilog/serial_output_format_control.sv
// interface format register and serial result framing on the data-out pin
`timescale 1ns/1ps
`default_nettype none
`include "serial_format_defs.svh"

// Functional notes
// - bit 7 selects boosted data-out drive
// - strap mode forces boosted drive on
// - bit 6 adds check byte to transfers
// - bit 5 uses xor, reads only
// - bit 5 clear uses crc-8 check
// - bit 4 appends status in continuous read
// - strap mode always appends status bits
// - bit 3 picks 24 or 16 bits
// - bit 2 shows ready on data-out in continuous read
// - bit 0 enables continuous read mode
// - reset clears register, bit 1 reserved
module serial_output_format_control
    import serial_format_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic pin_control_mode,
    input wire conv_s conv,
    input wire logic conv_valid,
    output logic sdo,
    output logic sdo_oe,
    output logic output_drive_boost,
    output ifmt_s interface_format,
    output logic check_fail
);

    logic [1:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] sdi_sync;
    logic [1:0] pin_sync;
    logic sclk_q;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic pin_mode;
    logic sdi_bit;

    logic [5:0] count;
    logic loaded;
    logic [7:0] rx_byte;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic [`TX_MSB:0] tx_shift;
    logic [`TX_MSB:0] next_tx;
    logic [`TX_MSB:0] frame_word;
    logic new_data;
    conv_s conv_hold;
    logic [7:0] xacc;
    logic [7:0] tx_crc;
    logic [7:0] rx_crc;

    logic cont;
    logic crc_on;
    logic status_on;
    logic is_read;
    logic addr_hit;
    logic [5:0] result_bits;
    logic [5:0] data_end;
    logic [5:0] region_end;
    logic in_tx;
    logic [7:0] check_byte;
    logic [7:0] rd_data;
    logic [7:0] rx_last;
    logic wr_plain;
    logic wr_checked;
    logic wr_commit;
    logic wr_bad;
    ifmt_s next_fmt;
    logic rdy_level;

    // pins arrive from the host clock domain, two stages before use
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_sync <= 2'h3;
            cs_sync <= 2'h3;
            sdi_sync <= 2'h0;
            pin_sync <= 2'h0;
            sclk_q <= 1'b1;
        end
        else
        begin
            sclk_sync <= {sclk_sync[0], sclk};
            cs_sync <= {cs_sync[0], cs_n};
            sdi_sync <= {sdi_sync[0], sdi};
            pin_sync <= {pin_sync[0], pin_control_mode};
            sclk_q <= sclk_sync[1];
        end
    end

    // sclk idles high: data moves on falling edges, is sampled on rising
    assign sclk_rise = sclk_sync[1] & ~sclk_q;
    assign sclk_fall = ~sclk_sync[1] & sclk_q;
    assign selected = ~cs_sync[1];
    assign pin_mode = pin_sync[1];
    assign sdi_bit = sdi_sync[1];

    assign cont = interface_format.continuous_read_enable;
    assign crc_on = interface_format.crc_en;
    assign status_on = pin_mode | interface_format.status_en;
    assign result_bits = interface_format.result_length_select ? `SHORT_W : `RESULT_W;
    assign data_end = status_on ? result_bits + `BYTE_W : result_bits;
    assign is_read = cmd[`CMD_READ_BIT];
    assign addr_hit = cmd[6:0] == `IFMT_ADDR;
    assign region_end = cont ? data_end : `DATA_END;
    assign rx_last = {rx_byte[6:0], sdi_bit};

    always_comb
    begin
        if (cont)
        begin
            in_tx = count < data_end;
        end
        else
        begin
            in_tx = is_read && count >= `CMD_END && count < `DATA_END;
        end
    end

    // the xor checksum only ever covers data the device sends
    assign check_byte = interface_format.xor_sel ? xacc : tx_crc;

    always_comb
    begin
        rd_data = 8'h00;
        if (addr_hit)
        begin
            rd_data = interface_format;
        end
    end

    // short results drop the low byte; status follows the kept bits
    always_comb
    begin
        frame_word = '0;
        if (interface_format.result_length_select)
        begin
            frame_word[`TX_MSB -: 16] = conv_hold.result[23:8];
            frame_word[`TX_MSB - 16 -: 8] = conv_hold.status;
        end
        else
        begin
            frame_word = {conv_hold.result, conv_hold.status};
        end
    end

    always_comb
    begin
        next_tx = tx_shift;
        if (!selected)
        begin
            next_tx = '0;
        end
        else if (sclk_fall)
        begin
            next_tx = {tx_shift[`TX_MSB - 1:0], 1'b0};
            if (!loaded && cont)
            begin
                next_tx = frame_word;
            end
            else if (!cont && is_read && count == `CMD_END)
            begin
                next_tx[`TX_MSB -: 8] = rd_data;
            end
            else if (crc_on && count == region_end && (cont || is_read))
            begin
                next_tx[`TX_MSB -: 8] = check_byte;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_shift <= '0;
        end
        else
        begin
            tx_shift <= next_tx;
        end
    end

    // ready shows low on data-out before the first clock of a frame
    assign rdy_level = cont & interface_format.rdy_en & ~new_data;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sdo <= 1'b0;
        end
        else if (!selected)
        begin
            sdo <= 1'b0;
        end
        else if (!loaded && !sclk_fall)
        begin
            sdo <= rdy_level;
        end
        else
        begin
            sdo <= next_tx[`TX_MSB];
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sdo_oe <= 1'b0;
        end
        else
        begin
            sdo_oe <= selected;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            loaded <= 1'b0;
        end
        else if (!selected)
        begin
            loaded <= 1'b0;
        end
        else if (sclk_fall)
        begin
            loaded <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            count <= '0;
        end
        else if (!selected)
        begin
            count <= '0;
        end
        else if (sclk_rise && count != `COUNT_MAX)
        begin
            count <= count + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_byte <= 8'h00;
            cmd <= 8'h00;
            wdata <= 8'h00;
        end
        else if (!selected)
        begin
            rx_byte <= 8'h00;
            cmd <= 8'h00;
        end
        else if (sclk_rise)
        begin
            rx_byte <= rx_last;
            if (count == `CMD_END - 6'h01)
            begin
                cmd <= rx_last;
            end
            if (count == `DATA_END - 6'h01)
            begin
                wdata <= rx_last;
            end
        end
    end

    // the result is held when conv_valid pulses; new data clears at the first falling edge; set beats clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            new_data <= 1'b0;
            conv_hold <= '0;
        end
        else if (conv_valid)
        begin
            new_data <= 1'b1;
            conv_hold <= conv;
        end
        else if (selected && sclk_fall && !loaded && cont)
        begin
            new_data <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            xacc <= 8'h00;
        end
        else if (!selected)
        begin
            xacc <= 8'h00;
        end
        else if (sclk_rise && in_tx)
        begin
            xacc[`BIT_IN_BYTE_MSB - count[2:0]] <= xacc[`BIT_IN_BYTE_MSB - count[2:0]] ^ sdo;
        end
    end

    crc8_unit tx_check
    (
        .mclk(mclk),
        .rstn(rstn),
        .clear(~selected),
        .shift(sclk_rise & in_tx),
        .din(sdo),
        .crc(tx_crc)
    );

    // writes with bit 6 set are checked with crc-8, whatever the xor select says
    crc8_unit rx_check
    (
        .mclk(mclk),
        .rstn(rstn),
        .clear(~selected),
        .shift(sclk_rise & crc_on & (count < `DATA_END)),
        .din(sdi_bit),
        .crc(rx_crc)
    );

    assign wr_plain = !crc_on && sclk_rise && count == `DATA_END - 6'h01;
    assign wr_checked = crc_on && sclk_rise && count == `CHK_END - 6'h01;
    assign wr_commit = selected && !is_read && addr_hit
        && (wr_plain || (wr_checked && rx_last == rx_crc));
    assign wr_bad = selected && !is_read && wr_checked && rx_last != rx_crc;

    always_comb
    begin
        next_fmt = wr_plain ? ifmt_s'(rx_last) : ifmt_s'(wdata);
        next_fmt.rsvd = 1'b0;
        if (interface_format.continuous_read_enable && !next_fmt.continuous_read_enable)
        begin
            next_fmt.output_drive_boost = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            interface_format <= ifmt_s'(`IFMT_RESET);
        end
        else if (wr_commit)
        begin
            interface_format <= next_fmt;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            check_fail <= 1'b0;
        end
        else
        begin
            check_fail <= wr_bad;
        end
    end

    // straps have no register path, so boost defaults on there
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            output_drive_boost <= 1'b0;
        end
        else
        begin
            output_drive_boost <= pin_mode | interface_format.output_drive_boost;
        end
    end

endmodule
`default_nettype wire

// >>> pkg/serial_format_defs.svh
// constants for the serial output format control block
`ifndef SERIAL_FORMAT_DEFS_SVH
`define SERIAL_FORMAT_DEFS_SVH

`define IFMT_ADDR 7'h14
`define IFMT_RESET 8'h00
`define CMD_READ_BIT 7
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define CMD_END 6'h08
`define DATA_END 6'h10
`define CHK_END 6'h18
`define RESULT_W 6'h18
`define SHORT_W 6'h10
`define BYTE_W 6'h08
`define COUNT_MAX 6'h3F
`define TX_MSB 31
`define BIT_IN_BYTE_MSB 3'h7

`endif

// >>> pkg/serial_format_pkg.sv
// types shared by the serial output format control block
package serial_format_pkg;

    typedef struct packed {
        logic output_drive_boost;
        logic crc_en;
        logic xor_sel;
        logic status_en;
        logic result_length_select;
        logic rdy_en;
        logic rsvd;
        logic continuous_read_enable;
    } ifmt_s;

    typedef struct packed {
        logic [23:0] result;
        logic [7:0] status;
    } conv_s;

endpackage

// >>> verilog/crc8_unit.sv
// bit-serial crc-8 engine, msb first
`timescale 1ns/1ps
`default_nettype none
`include "serial_format_defs.svh"

module crc8_unit
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic shift,
    input wire logic din,
    output logic [7:0] crc
);

    logic [7:0] next_crc;

    always_comb
    begin
        next_crc = {crc[6:0], 1'b0};
        if (crc[7] ^ din)
        begin
            next_crc = next_crc ^ `CRC_POLY;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            crc <= `CRC_INIT;
        end
        else if (clear)
        begin
            crc <= `CRC_INIT;
        end
        else if (shift)
        begin
            crc <= next_crc;
        end
    end

endmodule
`default_nettype wire

// >>> tb/spi_host_model.sv
// serial host model: mode 3 frames, sclk idle high
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
    input wire logic mclk,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic half();
        repeat (16) @(posedge mclk);
        #1;
    endtask
    // drive on falling sclk, sample sdo on rising sclk
    task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx,
        output logic rdy);
        rx = '0;
        cs_n = 1'b0;
        half();
        rdy = sdo;
        for (int k = 0; k < n; k++)
        begin
            sclk = 1'b0;
            sdi = tx[39 - k];
            half();
            sclk = 1'b1;
            rx = {rx[38:0], sdo};
            half();
        end
        // hold select past the last rising edge, or the device loses that bit
        half();
        cs_n = 1'b1;
        // released line has no pull, so it must not keep the last bit
        sdi = ~sdi;
        half();
    endtask
endmodule
`default_nettype wire

// >>> tb/serial_output_format_control_assertions.sv
// port checks for the interface format block
`timescale 1ns/1ps
`default_nettype none
module serial_output_format_control_assertions
    import serial_format_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic pin_control_mode,
    input wire conv_s conv,
    input wire logic conv_valid,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic output_drive_boost,
    input wire ifmt_s interface_format,
    input wire logic check_fail
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    chk_rsvd_low: assert property (interface_format.rsvd == 1'b0)
        else $error("reserved bit set");
    chk_boost_follows: assert property (
        interface_format.output_drive_boost [*2] |-> output_drive_boost)
        else $error("boost bit not driven");
    chk_normal_drive: assert property (
        (!pin_control_mode && !interface_format.output_drive_boost) [*5]
        |-> !output_drive_boost)
        else $error("boost without cause");
    chk_strap_boost: assert property (pin_control_mode [*5] |-> output_drive_boost)
        else $error("strap boost missing");
    chk_exit_clears: assert property (
        $fell(interface_format.continuous_read_enable)
        |-> !interface_format.output_drive_boost)
        else $error("boost kept on exit");
    chk_fail_pulse: assert property (check_fail |=> !check_fail)
        else $error("check fail too long");
    chk_fail_crc: assert property (check_fail |-> interface_format.crc_en)
        else $error("check fail without check");
    chk_fail_keeps: assert property (check_fail |-> $stable(interface_format))
        else $error("bad write taken");
    chk_sdo_quiet: assert property (cs_n [*6] |-> !sdo && !sdo_oe)
        else $error("sdo active while deselected");
    chk_oe_drive: assert property (!cs_n [*4] |-> sdo_oe)
        else $error("sdo not driven while selected");
endmodule
bind serial_output_format_control serial_output_format_control_assertions chk_u (
    .mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .pin_control_mode(pin_control_mode), .conv(conv), .conv_valid(conv_valid), .sdo(sdo),
    .sdo_oe(sdo_oe), .output_drive_boost(output_drive_boost),
    .interface_format(interface_format), .check_fail(check_fail));
`default_nettype wire

// >>> tb/serial_output_format_control_tb.sv
// self-checking bench for the interface format block
`timescale 1ns/1ps
`default_nettype none
`include "serial_format_defs.svh"
module serial_output_format_control_tb
    import serial_format_pkg::*;
();
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic pin_control_mode = 1'b0;
    logic conv_valid = 1'b0;
    conv_s conv = '0;
    logic sclk, cs_n, sdi, sdo, sdo_oe, output_drive_boost, check_fail, rdy;
    ifmt_s interface_format;
    int miscompares = 0;
    int total_checks = 0;
    int fail_count = 0;
    int n;
    logic [31:0] seed = 32'h9389_7225;
    logic [39:0] rx;
    logic [7:0] d;
    logic [7:0] cfg [4] = '{8'h9D, 8'h01, 8'h05, 8'h41};
    always #2.5 mclk = ~mclk;
    // the failure flag lasts one cycle; count it away from the edge that launches it
    always @(negedge mclk)
    begin
        if (check_fail !== 1'b0)
            fail_count++;
    end
    serial_output_format_control dut_u (.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
        .sdi(sdi), .pin_control_mode(pin_control_mode), .conv(conv), .conv_valid(conv_valid),
        .sdo(sdo), .sdo_oe(sdo_oe), .output_drive_boost(output_drive_boost),
        .interface_format(interface_format), .check_fail(check_fail));
    spi_host_model host_u (.mclk(mclk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] crc8(input logic [31:0] v, input int w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = w - 1; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    function automatic logic [39:0] frame_exp(input conv_s c, input logic [7:0] f, input logic p);
        logic [39:0] e;
        int w;
        e = f[3] ? 40'(c.result[23:8]) : 40'(c.result);
        w = f[3] ? 16 : 24;
        if (f[4] || p)
        begin
            e = {e[31:0], c.status};
            w = w + 8;
        end
        if (f[6])
            e = {e[31:0], crc8(e[31:0], w)};
        return e;
    endfunction
    task automatic compare(input logic [39:0] got, input logic [39:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // m: 0 no check byte, 1 good check byte, 2 corrupted check byte
    task automatic wr(input logic [6:0] a, input logic [7:0] v, input int m);
        logic [7:0] c;
        c = crc8({1'b0, a, v}, 16) ^ {8{m == 2}};
        host_u.xfer({1'b0, a, v, c, 16'h0000}, (m > 0) ? 24 : 16, rx, rdy);
    endtask
    task automatic rd(input logic [6:0] a, input int w);
        host_u.xfer({1'b1, a, 32'h0000_0000}, w, rx, rdy);
    endtask
    task automatic close_out();
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        close_out();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        rd(`IFMT_ADDR, 16);
        compare(rx[7:0], `IFMT_RESET);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            d = (seed[7:0] | 8'h02) & 8'hBE;
            wr(`IFMT_ADDR, d, 0);
            rd(`IFMT_ADDR, 16);
            compare(rx[7:0], d & 8'hFD);
            compare(output_drive_boost, d[7]);
            compare(interface_format, d & 8'hFD);
        end
        wr(7'h15, 8'hFF, 0);
        rd(7'h15, 16);
        compare(rx[7:0], 8'h00);
        rd(`IFMT_ADDR, 16);
        compare(rx[7:0], d & 8'hFD);
        wr(`IFMT_ADDR, 8'h40, 0);
        rd(`IFMT_ADDR, 24);
        compare(rx[15:0], {8'h40, crc8(16'h0040, 8)});
        wr(`IFMT_ADDR, 8'h00, 2);
        compare(fail_count, 1);
        rd(`IFMT_ADDR, 24);
        compare(rx[15:0], {8'h40, crc8(16'h0040, 8)});
        wr(`IFMT_ADDR, 8'h60, 1);
        rd(`IFMT_ADDR, 24);
        compare(rx[15:0], 16'h6060);
        wr(`IFMT_ADDR, 8'h00, 1);
        rd(`IFMT_ADDR, 16);
        compare(rx[7:0], 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(`IFMT_ADDR, cfg[i], 0);
            pin_control_mode = (i == 1);
            host_u.xfer('0, 8, rx, rdy);
            compare(rdy, cfg[i][2]);
            seed = lfsr(seed);
            @(posedge mclk);
            #1 conv = seed;
            conv_valid = 1'b1;
            @(posedge mclk);
            #1 conv_valid = 1'b0;
            n = (cfg[i][3] ? 16 : 24) + ((cfg[i][4] || i == 1) ? 8 : 0);
            n = n + (cfg[i][6] ? 8 : 0);
            host_u.xfer('0, n, rx, rdy);
            compare(rdy, 1'b0);
            compare(rx, frame_exp(conv, cfg[i], i == 1));
            compare(output_drive_boost, cfg[i][7] || i == 1);
            wr(`IFMT_ADDR, 8'h80, cfg[i][6] ? 1 : 0);
            pin_control_mode = 1'b0;
            rd(`IFMT_ADDR, 16);
            compare(rx[7:0], 8'h00);
        end
        wr(`IFMT_ADDR, 8'h80, 0);
        compare(output_drive_boost, 1'b1);
        compare(fail_count, 1);
        close_out();
    end
endmodule
`default_nettype wire
